// File: design/tob_ctrl.sv
// output conditioning, break protection and interrupt enables of a
// four-channel motor timer; apb slave with zero wait states.
// assumes compare and dead-time waveforms, events and break pin are
// synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
`include "tob_map.svh"
module tob_ctrl #(
  parameter int DTS_DIV = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic break_input_pin,
  input wire logic [3:0] chan_in,
  input wire logic [3:0] cmp_ref,
  input wire logic [2:0] cmp_ref_n,
  input wire logic [7:0] dead_time_cycles,
  input wire tob_pkg::tob_evt_type evt_in,
  output tob_pkg::tob_evt_type irq_req,
  output logic [3:0] capture_evt,
  output logic [3:0] chan_main_pin,
  output logic [3:0] chan_main_pin_oe_n,
  output logic [2:0] chan_comp_pin,
  output logic [2:0] chan_comp_pin_oe_n,
  output logic break_active
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] chctl_ff;
  logic [6:0] pol_ff;
  logic [6:0] idle_ff;
  tob_pkg::tob_brk_type brk_ff;
  logic moe_ff;
  logic lock_done_ff;
  logic [7:0] ien_ff;
  tob_pkg::tob_evt_type flag_ff;
  tob_pkg::tob_evt_type evg_ff;
  logic [31:0] rd_ff;
  logic [3:0] cap_prev_ff;
  logic [3:0] cap_ff;
  logic [7:0] dt_cnt_ff;
  logic [7:0] dts_div_ff;
  logic dg_smp_ff;
  logic [3:0] dg_cnt_ff;
  logic dg_ff;
  wire logic dts_tick = dts_div_ff == 8'(DTS_DIV - 1);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // zero wait states: the answer stands in the first access cycle
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic s_chctl = paddr == `TOB_CHCTL_OFS;
  wire logic s_pol = paddr == `TOB_POL_OFS;
  wire logic s_idle = paddr == `TOB_IDLE_OFS;
  wire logic s_brk = paddr == `TOB_BRK_OFS;
  wire logic s_ien = paddr == `TOB_IEN_OFS;
  wire logic s_evg = paddr == `TOB_EVG_OFS;
  wire logic s_sts = paddr == `TOB_STS_OFS;
  wire logic mapped = s_chctl | s_pol | s_idle | s_brk | s_ien | s_evg | s_sts;
  wire logic [1:0] lock = brk_ff.lock;
  // protection: level 1 freezes idle and break setup, 2 adds
  // polarity and off-state bits, 3 adds channel control
  wire logic lk1 = lock != 2'b00;
  wire logic lk2 = lock[1];
  wire logic lk3 = lock == 2'b11;
  wire logic wr_chctl = wr & s_chctl & ~lk3;
  wire logic wr_pol = wr & s_pol & ~lk2;
  wire logic wr_idle = wr & s_idle & ~lk1;
  wire logic wr_brk = wr & s_brk;
  wire logic wr_ien = wr & s_ien;
  wire logic wr_evg = wr & s_evg;
  wire logic wr_sts = wr & s_sts;

  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // picks the event bits out of a register word
  function automatic logic [7:0] evt_bits(input logic [31:0] w);
    evt_bits = {w[`TOB_EVT_HI_LSB +: 4], w[3:0]};
  endfunction : evt_bits
  // spreads event bits back into a register word
  function automatic logic [31:0] evt_word(input logic [7:0] e);
    evt_word = {20'h0_0000, e[7:4], 4'h0, e[3:0]};
  endfunction : evt_word

  // ----------------------------------------
  // break input path
  // ----------------------------------------
  // polarity first, so the filters always look for a high level
  wire logic brk_pol = brk_ff.break_polarity ? break_input_pin : ~break_input_pin;
  wire logic brk_dg = brk_ff.break_deglitch_select ? dg_ff : brk_pol;
  logic brk_filt;

  tob_brk_filter u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .brk_in(brk_dg),
    .code(brk_ff.break_filter_code),
    .dts_tick(dts_tick),
    .brk_out(brk_filt)
  );

  // break gate, then software break; both clear the enable at once
  wire logic brk_hw = brk_ff.break_gate & brk_filt;
  wire logic brk_now = brk_hw | evg_ff.brk;
  // combinational gating: pins go safe before any clock edge
  wire logic moe = moe_ff & ~brk_now;
  assign break_active = brk_now;

  // deglitch: a level must stand the full 50 ns before it passes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dg_smp_ff <= 1'b0;
      dg_cnt_ff <= 4'h0;
      dg_ff <= 1'b0;
    end else begin
      dg_smp_ff <= brk_pol;
      if (dg_smp_ff != brk_pol) dg_cnt_ff <= 4'h0;
      else if (dg_cnt_ff != 4'(`TOB_DEGLITCH_CYC)) dg_cnt_ff <= dg_cnt_ff + 4'h1;
      else dg_ff <= dg_smp_ff;
    end
  end

  // ----------------------------------------
  // dead-time clock and idle delay
  // ----------------------------------------
  // idle levels wait until the dead time has run out
  wire logic idle_ok = dt_cnt_ff >= dead_time_cycles;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dts_div_ff <= 8'h00;
      dt_cnt_ff <= 8'h00;
    end else begin
      dts_div_ff <= dts_tick ? 8'h00 : dts_div_ff + 8'h01;
      if (moe) dt_cnt_ff <= 8'h00;
      else if (dts_tick & ~idle_ok) dt_cnt_ff <= dt_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  wire logic upd1 = evt_in.upd1 | evg_ff.upd1;
  // main enable: break beats software, software beats auto set
  wire logic nxt_moe = brk_now ? 1'b0 :
                       wr_brk ? pwdata[`TOB_MOE_BIT] :
                       (brk_ff.aoe & upd1) ? 1'b1 : moe_ff;
  wire logic nxt_lock_wr = wr_brk & ~lock_done_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chctl_ff <= `TOB_CHCTL_RST;
      pol_ff <= `TOB_POL_RST;
      idle_ff <= `TOB_IDLE_RST;
      brk_ff <= tob_pkg::tob_brk_type'({10'h000, `TOB_BKP_RST, `TOB_BKE_RST});
      moe_ff <= 1'b0;
      lock_done_ff <= 1'b0;
      ien_ff <= `TOB_IEN_RST;
    end else begin
      moe_ff <= nxt_moe;
      if (wr_chctl) chctl_ff <= pwdata[15:0];
      if (wr_pol) pol_ff <= pwdata[6:0];
      if (wr_idle) idle_ff <= pwdata[6:0];
      if (wr_ien) ien_ff <= evt_bits(pwdata);
      if (wr_brk & ~lk2) begin
        brk_ff.ossr <= pwdata[`TOB_OSSR_BIT];
        brk_ff.ossi <= pwdata[`TOB_OSSI_BIT];
      end
      if (wr_brk & ~lk1) begin
        brk_ff.break_deglitch_select <= pwdata[`TOB_GF_BIT];
        brk_ff.break_filter_code <= pwdata[`TOB_BKF_LSB +: 4];
        brk_ff.aoe <= pwdata[`TOB_AOE_BIT];
        brk_ff.break_polarity <= pwdata[`TOB_BKP_BIT];
        brk_ff.break_gate <= pwdata[`TOB_BKE_BIT];
      end
      // the lock field takes only the first write after reset
      if (nxt_lock_wr) begin
        brk_ff.lock <= pwdata[`TOB_LOCK_LSB +: 2];
        lock_done_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // events, flags and requests
  // ----------------------------------------
  wire logic [7:0] set_v = evt_in | evg_ff | {brk_hw, 3'b000, cap_ff};
  // write 0 clears; a set in the same cycle wins
  wire logic [7:0] clr_v = wr_sts ? ~evt_bits(pwdata) : 8'h00;
  wire logic [7:0] nxt_flag = (flag_ff & ~clr_v) | set_v;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= '0;
      evg_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
      // generate bits are self clearing one-cycle pulses
      evg_ff <= wr_evg ? evt_bits(pwdata) : 8'h00;
    end
  end

  assign irq_req = flag_ff & ien_ff;

  // ----------------------------------------
  // capture edge select
  // ----------------------------------------
  // modes 1 to 3 make the channel an input
  wire logic [3:0] in_mode = {|chctl_ff[7:6], |chctl_ff[5:4],
                              |chctl_ff[3:2], |chctl_ff[1:0]};
  wire logic [3:0] cpol = {pol_ff[6], pol_ff[4], pol_ff[2], pol_ff[0]};
  wire logic [3:0] rise = chan_in & ~cap_prev_ff;
  wire logic [3:0] fall = ~chan_in & cap_prev_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev_ff <= 4'h0;
      cap_ff <= 4'h0;
    end else begin
      cap_prev_ff <= chan_in;
      cap_ff <= in_mode & ((cpol & fall) | (~cpol & rise));
    end
  end
  assign capture_evt = cap_ff;

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // returns {level, oe_n}; inactive level equals the polarity bit
  function automatic logic [1:0] drive(input logic ref_w, input logic pol,
      input logic on, input logic idle, input logic outm, input logic m,
      input logic ok);
    if (!outm) drive = 2'b01;
    else if (m) drive = on ? {ref_w ^ pol, 1'b0} :
                        brk_ff.ossr ? {pol, 1'b0} : 2'b01;
    else if (!brk_ff.ossi) drive = 2'b01;
    else drive = ok ? {idle, 1'b0} : {pol, 1'b0};
  endfunction : drive

  // break must reach the pins with no clock, so this stays combinational
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      {chan_main_pin[i], chan_main_pin_oe_n[i]} = drive(cmp_ref[i],
        pol_ff[2*i], chctl_ff[`TOB_CE_LSB+i], idle_ff[2*i], ~in_mode[i],
        moe, idle_ok);
      {chan_comp_pin[i], chan_comp_pin_oe_n[i]} = drive(cmp_ref_n[i],
        pol_ff[2*i+1], chctl_ff[`TOB_CNE_LSB+i], idle_ff[2*i+1],
        ~in_mode[i], moe, idle_ok);
    end
    // channel 3 has no dead time and no complementary output
    {chan_main_pin[3], chan_main_pin_oe_n[3]} = drive(cmp_ref[3], pol_ff[6],
      chctl_ff[`TOB_CE_LSB+3], idle_ff[6], ~in_mode[3], moe, 1'b1);
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  wire logic [31:0] brk_word = {10'h000, brk_ff.ossr, brk_ff.ossi, 1'b0,
    brk_ff.break_deglitch_select, brk_ff.lock, 4'h0, brk_ff.break_filter_code, 2'b00, brk_ff.aoe, moe,
    2'b00, brk_ff.break_polarity, brk_ff.break_gate};
  wire logic [31:0] rd_mux = s_chctl ? {16'h0000, chctl_ff} :
                             s_pol ? {25'h000_0000, pol_ff} :
                             s_idle ? {25'h000_0000, idle_ff} :
                             s_brk ? brk_word :
                             s_ien ? evt_word(ien_ff) :
                             s_sts ? evt_word(flag_ff) : 32'h0000_0000;

  // captured in the setup cycle so read data comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rd_ff <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite) rd_ff <= rd_mux;
  end
  assign prdata = rd_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_cap_edge;
    in_mode[0] & ~pol_ff[0] & chan_in[0] & ~cap_prev_ff[0] |=> capture_evt[0];
  endproperty
  a_cap_edge: assert property (p_cap_edge) else $error("rise missed");

  property p_main_pol;
    moe & ~in_mode[0] & chctl_ff[`TOB_CE_LSB] |->
      !chan_main_pin_oe_n[0] && chan_main_pin[0] == (cmp_ref[0] ^ pol_ff[0]);
  endproperty
  a_main_pol: assert property (p_main_pol) else $error("main level bad");

  property p_comp_pol;
    moe & ~in_mode[1] & chctl_ff[`TOB_CNE_LSB+1] |->
      chan_comp_pin[1] == (cmp_ref_n[1] ^ pol_ff[3]);
  endproperty
  a_comp_pol: assert property (p_comp_pol) else $error("comp level bad");

  property p_idle3;
    !moe & brk_ff.ossi & ~in_mode[3] |-> chan_main_pin[3] == idle_ff[6];
  endproperty
  a_idle3: assert property (p_idle3) else $error("ch3 idle bad");

  property p_idle0;
    !moe & brk_ff.ossi & idle_ok & ~in_mode[0] |->
      chan_main_pin[0] == idle_ff[0] && !chan_main_pin_oe_n[0];
  endproperty
  a_idle0: assert property (p_idle0) else $error("ch0 idle bad");

  property p_run_off;
    moe & ~brk_ff.ossr & ~chctl_ff[`TOB_CE_LSB] |-> chan_main_pin_oe_n[0];
  endproperty
  a_run_off: assert property (p_run_off) else $error("off pin driven");

  property p_lock;
    lock_done_ff & wr_brk |=> $stable(brk_ff.lock);
  endproperty
  a_lock: assert property (p_lock) else $error("lock rewritten");

  property p_brk;
    brk_hw |-> !brk_word[`TOB_MOE_BIT] ##1 !moe_ff && flag_ff.brk;
  endproperty
  a_brk: assert property (p_brk) else $error("break not taken");

  property p_auto;
    brk_ff.aoe & upd1 & ~brk_now & ~wr_brk |=> moe_ff;
  endproperty
  a_auto: assert property (p_auto) else $error("auto enable lost");

  property p_irq;
    flag_ff.brk & ien_ff[7] |-> irq_req.brk ##1 (irq_req.brk || !flag_ff.brk);
  endproperty
  a_irq: assert property (p_irq) else $error("break request low");
endmodule : tob_ctrl
`default_nettype wire

// File: design/tob_map.svh
// offsets, field positions, reset values and timing counts of the
// timer output and break control block; assumes a 32-bit apb word map
`ifndef TOB_MAP_SVH
`define TOB_MAP_SVH
// register byte offsets
`define TOB_CHCTL_OFS 12'h050
`define TOB_POL_OFS 12'h054
`define TOB_IDLE_OFS 12'h06C
`define TOB_BRK_OFS 12'h070
`define TOB_IEN_OFS 12'h074
`define TOB_EVG_OFS 12'h078
`define TOB_STS_OFS 12'h07C
// reset values
`define TOB_CHCTL_RST 16'h0000
`define TOB_POL_RST 7'h00
`define TOB_IDLE_RST 7'h00
`define TOB_BRK_RST 32'h0000_0002
`define TOB_IEN_RST 8'h00
`define TOB_BKP_RST 1'b1
`define TOB_BKE_RST 1'b0
// channel control: mode 2 bits per channel, then main and comp enables
`define TOB_CE_LSB 8
`define TOB_CNE_LSB 12
// break control fields
`define TOB_OSSR_BIT 21
`define TOB_OSSI_BIT 20
`define TOB_GF_BIT 18
`define TOB_LOCK_LSB 16
`define TOB_BKF_LSB 8
`define TOB_AOE_BIT 5
`define TOB_MOE_BIT 4
`define TOB_BKP_BIT 1
`define TOB_BKE_BIT 0
// event bits sit at 11:8 and 3:0 of enable, generate and status words
`define TOB_EVT_HI_LSB 8
// timing
`define TOB_CLK_NS 100
`define TOB_DEGLITCH_NS 50
`define TOB_DEGLITCH_CYC ((`TOB_DEGLITCH_NS + `TOB_CLK_NS - 1) / `TOB_CLK_NS)
`endif

// File: design/tob_pkg.sv
// types of the timer output and break control block
// assumes tob_map.svh supplies every number
package tob_pkg;
  // one bit per event, in status register order (high nibble first)
  typedef struct packed {
    logic brk;
    logic trg;
    logic upd2;
    logic upd1;
    logic [3:0] ch;
  } tob_evt_type;
  // break control fields held in flip-flops
  typedef struct packed {
    logic ossr;
    logic ossi;
    logic break_deglitch_select;
    logic [1:0] lock;
    logic [3:0] break_filter_code;
    logic aoe;
    logic break_polarity;
    logic break_gate;
  } tob_brk_type;
endpackage : tob_pkg

// File: design/tob_brk_filter.sv
// digital n-sample filter for the break input
// assumes brk_in is already polarity corrected and synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module tob_brk_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic brk_in,
  input wire logic [3:0] code,
  input wire logic dts_tick,
  output logic brk_out
);
  // ----------------------------------------
  // code decode
  // ----------------------------------------
  // agreeing samples needed per code
  function automatic logic [3:0] need_n(input logic [3:0] c);
    case (c)
      4'h1: need_n = 4'h2;
      4'h2: need_n = 4'h4;
      4'h4, 4'h6, 4'h8, 4'hB: need_n = 4'h6;
      4'hA, 4'hD: need_n = 4'h5;
      default: need_n = 4'h8;
    endcase
  endfunction : need_n
  // dts divider mask: divide by mask+1
  function automatic logic [4:0] div_mask(input logic [3:0] c);
    if (c < 4'h6) div_mask = 5'h01;
    else if (c < 4'h8) div_mask = 5'h03;
    else if (c < 4'hA) div_mask = 5'h07;
    else if (c < 4'hD) div_mask = 5'h0F;
    else div_mask = 5'h1F;
  endfunction : div_mask

  logic [4:0] div_ff;
  logic [3:0] cnt_ff;
  logic filt_ff;
  wire logic div_hit = dts_tick & ((div_ff & div_mask(code)) == div_mask(code));
  wire logic smp = (code < 4'h4) ? 1'b1 : div_hit;
  wire logic [3:0] nxt_cnt = cnt_ff + 4'h1;

  // ----------------------------------------
  // sampling divider and agreement counter
  // ----------------------------------------
  // the filter only moves after n agreeing samples in a row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 5'h00;
      cnt_ff <= 4'h0;
      filt_ff <= 1'b0;
    end else begin
      if (dts_tick) div_ff <= div_ff + 5'h01;
      if (smp) begin
        if (brk_in == filt_ff) cnt_ff <= 4'h0;
        else if (nxt_cnt == need_n(code)) begin
          filt_ff <= brk_in;
          cnt_ff <= 4'h0;
        end else cnt_ff <= nxt_cnt;
      end
    end
  end

  // code 0 bypasses the sampler so break acts with no clock
  assign brk_out = (code == 4'h0) ? brk_in : filt_ff;
endmodule : tob_brk_filter
`default_nettype wire

// File: test/tob_stage_model.sv
// power stage model on the far side of the timer outputs
// assumes the bench commands a trip; break pin is synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module tob_stage_model (
  input wire logic pclk,
  input wire logic trip,
  input wire logic trip_high,
  input wire logic [3:0] chan_main_pin,
  input wire logic [3:0] chan_main_pin_oe_n,
  output logic [3:0] gate_seen,
  output logic break_input_pin
);
  // ----------------------------------------
  // gate side and fault line
  // ----------------------------------------
  // gate drivers pull a released line low, so an undriven pin reads 0
  assign gate_seen = chan_main_pin & ~chan_main_pin_oe_n;
  // fault line only moves after an edge, like a synchronised source
  always_ff @(posedge pclk) begin
    break_input_pin <= trip ? trip_high : ~trip_high;
  end
endmodule : tob_stage_model
`default_nettype wire

// File: test/tob_ctrl_tb.sv
// self-checking bench of the output and break control block
// assumes the design package and map header are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "tob_map.svh"
module tob_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic break_input_pin, break_active, trip, trip_high;
  logic [11:0] paddr, ien;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] chan_in, cmp_ref, capture_evt, main_pin, main_oe_n, gate_seen, v0, v1, acc;
  logic [2:0] cmp_ref_n, comp_pin, comp_oe_n;
  logic [7:0] dead_time_cycles;
  logic [6:0] pol, idle;
  tob_pkg::tob_evt_type evt_in, irq_req, ev;
  int errors, checks;

  tob_ctrl #(.DTS_DIV(1)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .break_input_pin(break_input_pin),
    .chan_in(chan_in), .cmp_ref(cmp_ref), .cmp_ref_n(cmp_ref_n),
    .dead_time_cycles(dead_time_cycles), .evt_in(evt_in), .irq_req(irq_req),
    .capture_evt(capture_evt), .chan_main_pin(main_pin),
    .chan_main_pin_oe_n(main_oe_n), .chan_comp_pin(comp_pin),
    .chan_comp_pin_oe_n(comp_oe_n), .break_active(break_active)
  );
  tob_stage_model i_stage (
    .pclk(pclk), .trip(trip), .trip_high(trip_high), .chan_main_pin(main_pin),
    .chan_main_pin_oe_n(main_oe_n), .gate_seen(gate_seen),
    .break_input_pin(break_input_pin)
  );

  // ----------------------------------------
  // clock, checks and bus tasks
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // one compare point so every mismatch reads alike
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // apb transfer; waits on pready rather than assuming zero wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rdr
  function automatic logic [3:0] mpol(input logic [6:0] p);
    return {p[6], p[4], p[2], p[0]};
  endfunction : mpol
  function automatic logic [2:0] cpol(input logic [6:0] p);
    return {p[5], p[3], p[1]};
  endfunction : cpol
  function automatic logic [7:0] irq_exp(input logic [7:0] e, input logic [11:0] m);
    return e & {m[11:8], m[3:0]};
  endfunction : irq_exp
  // rising edges count when the bit is 0, falling when it is 1
  function automatic logic [3:0] cap_exp(input logic [3:0] a, input logic [3:0] b,
                                         input logic [3:0] p);
    return (b & ~a & ~p) | (a & ~b & p);
  endfunction : cap_exp
  // a short pulse must be swallowed, a long one must trip
  task automatic filt(input logic [31:0] cfg, input int shrt, input int lng);
    wr(`TOB_BRK_OFS, cfg);
    trip <= 1'b1;
    repeat (shrt) @(posedge pclk);
    trip <= 1'b0;
    repeat (lng) @(posedge pclk);
    rdr(`TOB_STS_OFS);
    chk(rd[11], 1'b0);
    trip <= 1'b1;
    repeat (lng) @(negedge pclk);
    chk(break_active, 1'b1);
    @(posedge pclk);
    trip <= 1'b0;
    repeat (lng) @(posedge pclk);
    wr(`TOB_STS_OFS, 32'h0000_0000);
  endtask : filt
  task automatic wrap_up;
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    chan_in = 4'h0;
    cmp_ref = 4'h0;
    cmp_ref_n = 3'h0;
    dead_time_cycles = 8'h00;
    evt_in = 8'h00;
    trip = 1'b0;
    trip_high = 1'b1;
    errors = 0;
    checks = 0;
    void'($urandom(99));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdr(`TOB_IEN_OFS);
    chk(rd, 32'h0000_0000);
    rdr(`TOB_IDLE_OFS);
    chk(rd, 32'h0000_0000);
    rdr(`TOB_BRK_OFS);
    chk(rd, 32'h0000_0002);
    rdr(12'h0F0);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    // lock field keeps its first value
    wr(`TOB_BRK_OFS, 32'h0000_0002);
    wr(`TOB_BRK_OFS, 32'h0003_0002);
    rdr(`TOB_BRK_OFS);
    chk(rd[17:16], 2'b00);
    repeat (6) begin
      ien = 12'($urandom) & 12'hF0F;
      ev = 8'($urandom);
      wr(`TOB_IEN_OFS, ien);
      rdr(`TOB_IEN_OFS);
      chk(rd, ien);
      @(posedge pclk);
      evt_in <= ev;
      @(posedge pclk);
      evt_in <= 8'h00;
      @(negedge pclk);
      chk(irq_req, irq_exp(ev, ien));
      wr(`TOB_STS_OFS, 32'h0000_0000);
    end
    // running outputs follow reference through polarity
    wr(`TOB_CHCTL_OFS, 32'h0000_7F00);
    wr(`TOB_BRK_OFS, 32'h0000_0012);
    repeat (4) begin
      pol = 7'($urandom);
      wr(`TOB_POL_OFS, pol);
      cmp_ref <= 4'($urandom);
      cmp_ref_n <= 3'($urandom);
      @(negedge pclk);
      chk({main_oe_n, comp_oe_n}, 7'h00);
      chk(main_pin, cmp_ref ^ mpol(pol));
      chk(comp_pin, cmp_ref_n ^ cpol(pol));
    end
    wr(`TOB_CHCTL_OFS, 32'h0000_0000);
    wr(`TOB_BRK_OFS, 32'h0020_0012);
    @(negedge pclk);
    chk({main_oe_n, comp_oe_n}, 7'h00);
    chk({main_pin, comp_pin}, {mpol(pol), cpol(pol)});
    wr(`TOB_BRK_OFS, 32'h0000_0012);
    @(negedge pclk);
    chk({main_oe_n, comp_oe_n}, 7'h7F);
    chk(gate_seen, 4'h0);
    // idle levels after the dead time
    idle = 7'($urandom);
    wr(`TOB_IDLE_OFS, idle);
    wr(`TOB_CHCTL_OFS, 32'h0000_7F00);
    dead_time_cycles <= 8'd3;
    wr(`TOB_BRK_OFS, 32'h0010_0002);
    @(negedge pclk);
    chk(main_pin[3], idle[6]);
    chk(main_pin[0], pol[0]);
    repeat (8) @(negedge pclk);
    chk(main_pin, mpol(idle));
    chk(comp_pin, cpol(idle));
    chk({main_oe_n, comp_oe_n}, 7'h00);
    wr(`TOB_BRK_OFS, 32'h0000_0002);
    @(negedge pclk);
    chk({main_oe_n, comp_oe_n}, 7'h7F);
    // hardware break, high active, no filter
    wr(`TOB_BRK_OFS, 32'h0000_0013);
    trip <= 1'b1;
    @(negedge pclk);
    @(negedge pclk);
    chk(break_active, 1'b1);
    chk({main_oe_n, comp_oe_n}, 7'h7F);
    @(posedge pclk);
    trip <= 1'b0;
    rdr(`TOB_BRK_OFS);
    chk(rd[4], 1'b0);
    rdr(`TOB_STS_OFS);
    chk(rd[11], 1'b1);
    wr(`TOB_STS_OFS, 32'h0000_0000);
    rdr(`TOB_STS_OFS);
    chk(rd[11], 1'b0);
    // low active break, then gate closed
    wr(`TOB_BRK_OFS, 32'h0000_0002);
    trip_high <= 1'b0;
    wr(`TOB_BRK_OFS, 32'h0000_0011);
    trip <= 1'b1;
    @(negedge pclk);
    chk(break_active, 1'b0);
    @(negedge pclk);
    chk(break_active, 1'b1);
    wr(`TOB_BRK_OFS, 32'h0000_0000);
    wr(`TOB_BRK_OFS, 32'h0000_0010);
    @(negedge pclk);
    chk(break_active, 1'b0);
    rdr(`TOB_BRK_OFS);
    chk(rd[4], 1'b1);
    trip <= 1'b0;
    trip_high <= 1'b1;
    wr(`TOB_STS_OFS, 32'h0000_0000);
    // software break
    wr(`TOB_BRK_OFS, 32'h0000_0012);
    wr(`TOB_EVG_OFS, 32'h0000_0800);
    repeat (3) @(posedge pclk);
    rdr(`TOB_BRK_OFS);
    chk(rd[4], 1'b0);
    rdr(`TOB_STS_OFS);
    chk(rd[11], 1'b1);
    wr(`TOB_STS_OFS, 32'h0000_0000);
    // update event 1 sets main enable only with auto enable
    for (int a = 1; a >= 0; a--) begin
      wr(`TOB_BRK_OFS, a ? 32'h0000_0022 : 32'h0000_0002);
      evt_in <= 8'h10;
      @(posedge pclk);
      evt_in <= 8'h00;
      rdr(`TOB_BRK_OFS);
      chk(rd[4], a[0]);
    end
    wr(`TOB_STS_OFS, 32'h0000_0000);
    // deglitch delays the break, then the digital filters
    wr(`TOB_BRK_OFS, 32'h0004_0003);
    trip <= 1'b1;
    @(negedge pclk);
    @(negedge pclk);
    chk(break_active, 1'b0);
    repeat (4) @(negedge pclk);
    chk(break_active, 1'b1);
    @(posedge pclk);
    trip <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(`TOB_STS_OFS, 32'h0000_0000);
    filt(32'h0000_0103, 1, 10);
    filt(32'h0000_0303, 4, 24);
    filt(32'h0000_0403, 6, 40);
    filt(32'h0000_0903, 30, 150);
    filt(32'h0000_0E03, 100, 400);
    // capture edges over every input mode code
    wr(`TOB_CHCTL_OFS, 32'h0000_0079);
    v0 = 4'h0;
    repeat (8) begin
      pol = 7'($urandom);
      wr(`TOB_POL_OFS, pol);
      v1 = 4'($urandom);
      chan_in <= v1;
      acc = 4'h0;
      repeat (4) begin
        @(negedge pclk);
        acc = acc | capture_evt;
      end
      chk(acc, cap_exp(v0, v1, mpol(pol)));
      v0 = v1;
    end
    // a second reset reopens the lock field; level 3 then freezes setup
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    wr(`TOB_BRK_OFS, 32'h0003_0002);
    wr(`TOB_IDLE_OFS, 32'h0000_007F);
    wr(`TOB_CHCTL_OFS, 32'h0000_0F00);
    rdr(`TOB_BRK_OFS);
    chk(rd[17:16], 2'b11);
    rdr(`TOB_IDLE_OFS);
    chk(rd, 32'h0000_0000);
    rdr(`TOB_CHCTL_OFS);
    chk(rd, 32'h0000_0000);
    wrap_up();
  end

  // hang guard, well beyond the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    wrap_up();
  end
endmodule : tob_ctrl_tb
`default_nettype wire
